// ==== design/ssr_pkg.sv ====
// Constants, types and helpers for the serial receiver status block
package ssr_pkg;
  // Clock and line rate
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam int OVERSAMPLE = 16;
  localparam int SAMPLE_DIV = CLK_HZ / (BAUD_HZ * OVERSAMPLE);
  localparam logic [5:0] SAMPLE_LAST = 6'(SAMPLE_DIV - 1);
  // Sample positions inside one bit time and sample vote thresholds
  localparam logic [3:0] START_SMP_LO = 4'h3;
  localparam logic [3:0] START_SMP_HI = 4'h9;
  localparam logic [3:0] BIT_SMP_LO = 4'h7;
  localparam logic [3:0] BIT_SMP_HI = 4'h9;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [2:0] START_MAX_ONES = 3'h3;
  localparam logic [2:0] BIT_ALL_ONES = 3'h3;
  localparam logic [2:0] BIT_MAJORITY = 3'h2;
  // Byte offsets on the bus
  localparam logic [7:0] OFF_STATUS_ONE = 8'h00;
  localparam logic [7:0] OFF_STATUS_TWO = 8'h04;
  localparam logic [7:0] OFF_DATA_PORT = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0c;
  // Field positions
  localparam int S1_RX_DATA_FULL_FLAG = 5;
  localparam int S1_IDLE = 4;
  localparam int S1_OVERRUN = 3;
  localparam int S1_NOISE = 2;
  localparam int S1_FRAMING = 1;
  localparam int S1_PARITY = 0;
  localparam int S2_LONG_BREAK = 2;
  localparam int S2_ACTIVE = 0;
  localparam int CTL_ENABLE = 0;
  localparam int CTL_NINE_BIT = 1;
  localparam int CTL_PARITY_EN = 2;
  localparam int CTL_PARITY_ODD = 3;
  localparam int CTL_IDLE_AFTER_STOP = 4;
  localparam logic [4:0] CTL_RESET = 5'h00;
  // Frame and break lengths in bit times, buffer depth in entries
  localparam logic [3:0] FRAME_SHORT = 4'ha;
  localparam logic [3:0] FRAME_LONG = 4'hb;
  localparam logic [3:0] BREAK_EXTRA = 4'h3;
  localparam logic [3:0] START_STOP_BITS = 4'h2;
  localparam logic [3:0] IDLE_SAT = 4'hf;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA = 4'b0100,
    ST_STOP = 4'b1000
  } ssr_state_t;

  typedef struct packed {
    logic noise;
    logic framing;
    logic parity;
    logic [8:0] data;
  } ssr_char_t;

  function automatic logic [3:0] frame_bits(input logic nine_bit);
    frame_bits = nine_bit ? FRAME_LONG : FRAME_SHORT;
  endfunction
endpackage

// ==== design/ssr_top.sv ====
// Serial receiver with status flags, two-deep receive buffer, Wishbone slave
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module ssr_top (
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Wishbone slave
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial line and status
  input logic rx_i,
  output logic rx_active_o,
  output logic [3:0] break_bits_o
);
  import ssr_pkg::*;

  logic [5:0] smp_div;
  logic smp_tick;
  logic [4:0] ctrl;
  logic long_break;
  ssr_state_t st;
  logic [3:0] tick;
  logic [3:0] bit_idx;
  logic [2:0] ones;
  logic [2:0] ones_nx;
  logic in_win;
  logic noise;
  logic [8:0] shreg;
  logic [3:0] idle_bits;
  logic [3:0] idle_ticks;
  logic idle_hit;
  logic idle_flag;
  logic idle_armed;
  logic active_flag;
  logic overrun_flag;
  logic arm_rx_data_full_flag;
  logic arm_idle;
  logic arm_or;
  ssr_char_t buf_mem [2];
  logic wptr;
  logic rptr;
  logic [1:0] cnt;
  ssr_char_t new_char;
  ssr_char_t head;
  logic char_done;
  logic start_ok;
  logic stop_val;
  logic bit_val;
  logic in_ready;
  logic push;
  logic pop;
  logic rx_data_full_flag;
  logic acc;
  logic rd_s1;
  logic rd_data;
  logic wr_acc;
  logic [7:0] reg_adr;
  logic [3:0] ndata;
  logic [31:0] next_rdat;

  // Oversampling tick
  assign smp_tick = (smp_div == SAMPLE_LAST);
  always_ff @(posedge clk_i) begin
    if (rst_i || smp_tick) begin
      smp_div <= 6'h00;
    end else begin
      smp_div <= smp_div + 6'h01;
    end
  end

  // Sample bookkeeping
  assign in_win = (st == ST_START) ? (tick >= START_SMP_LO && tick <= START_SMP_HI)
                                   : (tick >= BIT_SMP_LO && tick <= BIT_SMP_HI);
  assign ones_nx = ones + {2'b00, rx_i & in_win};
  assign bit_val = (ones >= BIT_MAJORITY);
  assign stop_val = (ones_nx >= BIT_MAJORITY);
  assign ndata = frame_bits(ctrl[CTL_NINE_BIT]) - START_STOP_BITS;
  assign start_ok = smp_tick && st == ST_START && tick == START_SMP_HI
                    && ones_nx <= START_MAX_ONES;
  assign char_done = smp_tick && st == ST_STOP && tick == BIT_SMP_HI;

  // Character assembled at the stop bit
  always_comb begin
    new_char.data = ctrl[CTL_NINE_BIT] ? shreg : {1'b0, shreg[8:1]};
    new_char.noise = noise || (ones_nx != 3'h0 && ones_nx != BIT_ALL_ONES);
    new_char.framing = !stop_val;
    new_char.parity = ctrl[CTL_PARITY_EN] && ((^new_char.data) != ctrl[CTL_PARITY_ODD]);
  end

  // Receive state machine
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl[CTL_ENABLE]) begin
      st <= ST_IDLE;
      tick <= 4'h0;
      bit_idx <= 4'h0;
      ones <= 3'h0;
      noise <= 1'b0;
      shreg <= 9'h000;
    end else if (smp_tick) begin
      unique case (st)
        ST_IDLE: begin
          if (!rx_i) begin
            st <= ST_START;
            tick <= 4'h0;
            ones <= 3'h0;
            noise <= 1'b0;
          end
        end
        ST_START: begin
          tick <= tick + 4'h1;
          ones <= ones_nx;
          if (tick == START_SMP_HI) begin
            if (ones_nx > START_MAX_ONES) begin
              st <= ST_IDLE;
            end
            noise <= (ones_nx != 3'h0);
          end
          if (tick == TICK_LAST) begin
            st <= ST_DATA;
            bit_idx <= 4'h0;
            ones <= 3'h0;
          end
        end
        ST_DATA: begin
          tick <= tick + 4'h1;
          ones <= ones_nx;
          if (tick == TICK_LAST) begin
            shreg <= {bit_val, shreg[8:1]};
            noise <= noise || (ones != 3'h0 && ones != BIT_ALL_ONES);
            ones <= 3'h0;
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == ndata - 4'h1) begin
              st <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          tick <= tick + 4'h1;
          ones <= ones_nx;
          if (tick == BIT_SMP_HI) begin
            st <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Idle time counting in bit times
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl[CTL_ENABLE]) begin
      idle_bits <= 4'h0;
      idle_ticks <= 4'h0;
    end else if (smp_tick) begin
      if (st == ST_IDLE) begin
        idle_ticks <= rx_i ? idle_ticks + 4'h1 : 4'h0;
        if (!rx_i) begin
          idle_bits <= 4'h0;
        end else if (idle_ticks == TICK_LAST && idle_bits != IDLE_SAT) begin
          idle_bits <= idle_bits + 4'h1;
        end
      end
      if (st == ST_DATA && tick == TICK_LAST && !ctrl[CTL_IDLE_AFTER_STOP]) begin
        idle_bits <= bit_val ? idle_bits + 4'h1 : 4'h0;
      end
      if (char_done) begin
        idle_ticks <= 4'h0;
        if (ctrl[CTL_IDLE_AFTER_STOP] || !stop_val) begin
          idle_bits <= 4'h0;
        end else begin
          idle_bits <= idle_bits + 4'h1;
        end
      end
    end
  end
  assign idle_hit = (st == ST_IDLE) && (idle_bits >= frame_bits(ctrl[CTL_NINE_BIT]));

  // Two-entry receive buffer; a reader that stalls fills it, then overrun
  assign in_ready = (cnt != BUF_DEPTH);
  assign push = char_done && in_ready;
  assign rx_data_full_flag = (cnt != 2'h0);
  assign head = buf_mem[rptr];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      cnt <= 2'h0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else begin
      if (push) begin
        buf_mem[wptr] <= new_char;
        wptr <= !wptr;
      end
      if (pop) begin
        rptr <= !rptr;
      end
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Bus decode; the request is taken on the edge that raises ack
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign reg_adr = {wb_adr_i[7:2], 2'b00};
  assign wr_acc = acc && wb_we_i && wb_sel_i[0];
  assign rd_s1 = acc && !wb_we_i && reg_adr == OFF_STATUS_ONE;
  assign rd_data = acc && !wb_we_i && reg_adr == OFF_DATA_PORT;
  // clear only after a status read that saw it
  assign pop = rd_data && arm_rx_data_full_flag && rx_data_full_flag;

  // Snapshot of flags seen by the status read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_rx_data_full_flag <= 1'b0;
      arm_idle <= 1'b0;
      arm_or <= 1'b0;
    end else if (rd_s1) begin
      arm_rx_data_full_flag <= rx_data_full_flag;
      arm_idle <= idle_flag;
      arm_or <= overrun_flag;
    end else if (rd_data) begin
      arm_rx_data_full_flag <= 1'b0;
      arm_idle <= 1'b0;
      arm_or <= 1'b0;
    end
  end

  // Idle flag and its rearm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_flag <= 1'b0;
      idle_armed <= 1'b0;
    end else begin
      idle_flag <= (idle_hit && idle_armed) || (idle_flag && !(rd_data && arm_idle));
      if (push) begin
        idle_armed <= 1'b1;
      end else if (idle_hit) begin
        idle_armed <= 1'b0;
      end
    end
  end

  // Overrun flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun_flag <= 1'b0;
    end else begin
      overrun_flag <= (char_done && !in_ready) || (overrun_flag && !(rd_data && arm_or));
    end
  end

  // Receiver active flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_flag <= 1'b0;
    end else if (start_ok) begin
      active_flag <= 1'b1;
    end else if (idle_hit || !ctrl[CTL_ENABLE]) begin
      active_flag <= 1'b0;
    end
  end
  assign rx_active_o = active_flag;

  // Writable control bits; status one and the active bit ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTL_RESET;
      long_break <= 1'b0;
    end else if (wr_acc) begin
      if (reg_adr == OFF_CONTROL) begin
        ctrl <= wb_dat_i[4:0];
      end
      // only the break select is written
      if (reg_adr == OFF_STATUS_TWO) begin
        long_break <= wb_dat_i[S2_LONG_BREAK];
      end
    end
  end

  // break length for the transmit side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      break_bits_o <= FRAME_SHORT;
    end else begin
      break_bits_o <= frame_bits(ctrl[CTL_NINE_BIT]) + (long_break ? BREAK_EXTRA : 4'h0);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdat = 32'h0000_0000;
    unique case (reg_adr)
      OFF_STATUS_ONE: begin
        next_rdat[S1_RX_DATA_FULL_FLAG] = rx_data_full_flag;
        next_rdat[S1_IDLE] = idle_flag;
        next_rdat[S1_OVERRUN] = overrun_flag;
        next_rdat[S1_NOISE] = rx_data_full_flag && head.noise;
        next_rdat[S1_FRAMING] = rx_data_full_flag && head.framing;
        next_rdat[S1_PARITY] = rx_data_full_flag && head.parity;
      end
      OFF_STATUS_TWO: begin
        next_rdat[S2_LONG_BREAK] = long_break;
        next_rdat[S2_ACTIVE] = active_flag;
      end
      OFF_DATA_PORT: next_rdat[8:0] = head.data;
      OFF_CONTROL: next_rdat[4:0] = ctrl;
      default: next_rdat = 32'h0000_0000;
    endcase
  end

  // Single-wait-state answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        wb_dat_o <= next_rdat;
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  idle_after_count_a: assert property ($rose(idle_flag) |-> $past(idle_bits) >=
    frame_bits($past(ctrl[CTL_NINE_BIT]))) else $error("idle set too early");
  idle_once_a: assert property ($rose(idle_flag) |-> !idle_armed)
    else $error("idle not disarmed");
  idle_clear_a: assert property (rd_data && arm_idle && !idle_hit |=> !idle_flag)
    else $error("idle not cleared");
  overrun_full_a: assert property (char_done && cnt == BUF_DEPTH && !pop |=>
    overrun_flag && cnt == BUF_DEPTH) else $error("overrun lost or char kept");
  overrun_keep_a: assert property (rd_data && !arm_or && overrun_flag |=> overrun_flag)
    else $error("overrun cleared without status read");
  overrun_clear_a: assert property (rd_data && arm_or && !char_done |=> !overrun_flag)
    else $error("overrun not cleared");
  active_start_a: assert property ($rose(active_flag) |->
    $past(start_ok) && st == ST_START) else $error("active set without valid start");
  active_idle_a: assert property ($rose(idle_flag) |-> !active_flag)
    else $error("active stays on idle");
  rx_data_full_flag_push_a: assert property (push && cnt == 2'h0 |=> rx_data_full_flag && head == $past(new_char))
    else $error("character not posted");
  brk_len_a: assert property (long_break && ctrl[CTL_NINE_BIT] |=> break_bits_o == 4'he)
    else $error("long break length wrong");

  idle_seen_c: cover property ($rose(idle_flag));
  overrun_seen_c: cover property ($rose(overrun_flag));
  framing_seen_c: cover property (push && new_char.framing);
  noise_seen_c: cover property (push && new_char.noise);
endmodule

// ==== testbench/ssr_line_model.sv ====
// Behavioural remote serial transmitter driving the receive line
`timescale 1ns/1ps
module ssr_line_model
  import ssr_pkg::*;
#(
  parameter int BIT_CLKS = 16 * SAMPLE_DIV
) (
  // Clock
  input wire logic clk_i,
  // Serial line
  output logic line_o
);
  localparam int TICK = BIT_CLKS / 16;

  initial line_o = 1'b1;

  task automatic hold(input logic lvl, input int n);
    line_o <= lvl;
    repeat (n) @(posedge clk_i);
  endtask

  // One frame: start, 8 bits LSB first, stop; optional glitch of one tick
  task automatic send(input logic [7:0] d, input logic bad_stop, input int glitch_bit);
    @(posedge clk_i);
    hold(1'b0, BIT_CLKS);
    for (int i = 0; i < 8; i++) begin
      if (i == glitch_bit) begin
        // One tick wide over the middle sample; any start phase
        // leaves exactly one of three samples disagreeing
        hold(d[i], 9 * TICK);
        hold(~d[i], TICK);
        hold(d[i], BIT_CLKS - 10 * TICK);
      end else begin
        hold(d[i], BIT_CLKS);
      end
    end
    hold(~bad_stop, BIT_CLKS);
    // Line returns high after a low stop so the next start is clean
    if (bad_stop) begin
      hold(1'b1, BIT_CLKS);
    end
    line_o <= 1'b1;
  endtask
endmodule

// ==== testbench/test_ssr_top.sv ====
// Self-checking bench for the serial receiver status block
`timescale 1ns/1ps
module test_ssr_top;
  import ssr_pkg::*;
  localparam int BIT_CLKS = 16 * SAMPLE_DIV;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic rx;
  logic active;
  logic [3:0] brk;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int check_count = 0;

  ssr_top i_ssr_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_i(rx), .rx_active_o(active), .break_bits_o(brk));
  ssr_line_model #(.BIT_CLKS(BIT_CLKS)) i_ssr_line_model (.clk_i(clk_i), .line_o(rx));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; read expectations go to the queue
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    if (!w) begin
      exp_q.push_back(e);
    end
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic wait_bits(input int n);
    repeat (n * BIT_CLKS) @(posedge clk_i);
  endtask

  // Read results taken at the ack edge against the oldest note
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      check(rdat, exp_q.size() > 0 ? exp_q.pop_front() : 32'hffff_ffff);
    end
  end

  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    r = $urandom(58);
    // Registers after reset and write protection
    bus(1'b0, OFF_STATUS_ONE, 32'h0000_0000, 32'h0000_0000);
    bus(1'b0, OFF_STATUS_TWO, 32'h0000_0000, 32'h0000_0000);
    check({28'h000_0000, brk}, 32'h0000_000a);
    bus(1'b1, 8'h10, $urandom(), 32'h0000_0000);
    bus(1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000);
    bus(1'b1, OFF_STATUS_ONE, $urandom() | 32'h0000_00ff, 32'h0000_0000);
    bus(1'b0, OFF_STATUS_ONE, 32'h0000_0000, 32'h0000_0000);
    bus(1'b1, OFF_STATUS_TWO, $urandom() | 32'h0000_00ff, 32'h0000_0000);
    bus(1'b0, OFF_STATUS_TWO, 32'h0000_0000, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    check({28'h000_0000, brk}, 32'h0000_000d);
    bus(1'b1, OFF_CONTROL, 32'h0000_0003, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    check({28'h000_0000, brk}, 32'h0000_000e);
    $display("test registers done");
    // Noise, parity and framing errors, then overrun; long break still set
    bus(1'b1, OFF_CONTROL, 32'h0000_0005, 32'h0000_0000);
    i_ssr_line_model.send(8'h41, 1'b0, 0);
    check({31'h0000_0000, active}, 32'h0000_0001);
    i_ssr_line_model.send(8'h07, 1'b1, -1);
    i_ssr_line_model.send(8'h55, 1'b0, -1);
    wait_bits(12);
    check({31'h0000_0000, active}, 32'h0000_0000);
    bus(1'b0, OFF_STATUS_ONE, 32'h0000_0000, 32'h0000_003c);
    bus(1'b0, OFF_DATA_PORT, 32'h0000_0000, 32'h0000_0041);
    bus(1'b0, OFF_STATUS_ONE, 32'h0000_0000, 32'h0000_0023);
    bus(1'b0, OFF_DATA_PORT, 32'h0000_0000, 32'h0000_0007);
    bus(1'b0, OFF_STATUS_ONE, 32'h0000_0000, 32'h0000_0000);
    $display("test errors done");
    // Idle counted only after the stop bit
    bus(1'b1, OFF_CONTROL, 32'h0000_0011, 32'h0000_0000);
    i_ssr_line_model.send(8'hff, 1'b0, -1);
    wait_bits(4);
    bus(1'b0, OFF_STATUS_ONE, 32'h0000_0000, 32'h0000_0020);
    wait_bits(8);
    bus(1'b0, OFF_STATUS_ONE, 32'h0000_0000, 32'h0000_0030);
    bus(1'b0, OFF_DATA_PORT, 32'h0000_0000, 32'h0000_00ff);
    bus(1'b0, OFF_STATUS_ONE, 32'h0000_0000, 32'h0000_0000);
    check({31'h0000_0000, active}, 32'h0000_0000);
    $display("test idle done");
    // Idle counted from the start bit, odd parity
    bus(1'b1, OFF_CONTROL, 32'h0000_000d, 32'h0000_0000);
    i_ssr_line_model.send(8'hff, 1'b0, -1);
    wait_bits(2);
    bus(1'b0, OFF_STATUS_ONE, 32'h0000_0000, 32'h0000_0031);
    bus(1'b0, OFF_DATA_PORT, 32'h0000_0000, 32'h0000_00ff);
    bus(1'b0, OFF_STATUS_ONE, 32'h0000_0000, 32'h0000_0000);
    $display("test idle from start done");
    repeat (3) @(posedge clk_i);
    stop_test();
  end
endmodule
